// >>> rtl/sld_link_setup.sv
// Quick-setup decoder and register file for the four-lane serial transmit link.
//
// Behaviour
// R1: The first L output lanes form one link and are enabled together.
// R2: One quick-setup code selects lane count, converter count and octets per frame.
// R3: With downconverters active, converter count must equal virtual converter count.
// R4: Lane rate equals M times N' times 10/8 times sample rate over L.
// R5: Sample rate is converter clock divided by the programmed decimation ratio.
// R6: Controller powers link down, writes code, options, then powers link up.
// R7: Controller sets 0x10 in lane-rate control below 6.25 Gbps.
// R8: Controller clears low-rate bit for rates 6.25 to 12.5 Gbps.
// R9: Controller keeps lane rate within 3.125 to 12.5 Gbps inclusive.
// R10: 16-bit, one converter codes decode to fixed lanes, octets and high density.
// R11: 16-bit codes for two, four and eight converters decode per table.
// R12: Resolution and control bit ranges depend on container width.
// R13: 8-bit, one converter codes decode per table, high density clear.
// R14: 8-bit, two converter codes decode per table, high density clear.
// R15: Multiframe length is a multiple of four with a minimum set by F.
// R16: PLL status bit 7 reads back whether the serializer PLL locked.
// R17: Controller keeps low-rate bit consistent with the actual lane rate.
// R18: Each code decodes according to the configured container width.
`timescale 1ns/100ps
`include "sld_cfg.svh"

module sld_link_setup
  import sld_pkg::*;
(
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  // Register port.
  input  wire logic [11:0] i_reg_addr,
  input  wire logic        i_reg_wr,
  input  wire logic [7:0]  i_reg_wdata,
  input  wire logic        i_reg_rd,
  output logic      [7:0]  o_reg_rdata,
  output logic             o_reg_rvalid,
  // Status from the rest of the converter.
  input  wire logic        i_pll_locked,
  input  wire logic        i_ddc_active,
  input  wire logic [3:0]  i_virt_conv,
  // Decoded link parameters.
  output logic      [3:0]  o_lane_en,
  output logic      [2:0]  o_lanes,
  output logic      [3:0]  o_conv,
  output logic      [4:0]  o_octets,
  output logic      [3:0]  o_spf,
  output logic             o_hd,
  output logic      [4:0]  o_np,
  output logic      [4:0]  o_res_min,
  output logic      [4:0]  o_res_max,
  output logic      [1:0]  o_cs_max,
  output logic      [5:0]  o_k_min,
  output logic      [9:0]  o_rate_x4,
  output logic             o_cfg_ok,
  output logic             o_m_mismatch,
  output logic             o_low_line_rate,
  // Output sample strobe.
  output logic             o_sample_en
);

  // Software-visible registers, then the divider count and internal decode signals.
  logic [7:0] dcm_r;
  logic [7:0] lane_rate_r;
  logic [7:0] quick_r;
  logic [7:0] link_ctrl_r;
  logic [7:0] div_cnt_r;
  logic [7:0] ratio;
  logic       n8;
  logic       power_up;
  sld_qcfg_t  dec;
  logic [3:0] lg_n;
  logic [3:0] lg_s;
  logic [3:0] lg_r;

  // Builds one table entry from logarithmic counts.
  function automatic sld_qcfg_t entry(input logic [1:0] l, input logic [1:0] m,
                                      input logic [2:0] f, input logic hd);
    sld_qcfg_t e;
    e.ok   = 1'b1;
    e.lg_l = l;
    e.lg_m = m;
    e.lg_f = f;
    e.hd   = hd;
    return e;
  endfunction

  // The same code means different settings per container width, so width
  // is part of the case key; unlisted codes decode as not ok.
  function automatic sld_qcfg_t decode(input logic [7:0] code, input logic w8);
    sld_qcfg_t e;
    e = '0;
    unique case ({w8, code})
      {1'b0, 8'h01}: e = entry(2'h0, 2'h0, 3'h1, 1'b0); // R10
      {1'b0, 8'h40}: e = entry(2'h1, 2'h0, 3'h0, 1'b1); // R10
      {1'b0, 8'h41}: e = entry(2'h1, 2'h0, 3'h1, 1'b0); // R10
      {1'b0, 8'h80}: e = entry(2'h2, 2'h0, 3'h0, 1'b1); // R10
      {1'b0, 8'h81}: e = entry(2'h2, 2'h0, 3'h1, 1'b0); // R10
      {1'b0, 8'h0a}: e = entry(2'h0, 2'h1, 3'h2, 1'b0); // R11
      {1'b0, 8'h49}: e = entry(2'h1, 2'h1, 3'h1, 1'b0); // R11
      {1'b0, 8'h88}: e = entry(2'h2, 2'h1, 3'h0, 1'b1); // R11
      {1'b0, 8'h89}: e = entry(2'h2, 2'h1, 3'h1, 1'b0); // R11
      {1'b0, 8'h13}: e = entry(2'h0, 2'h2, 3'h3, 1'b0); // R11
      {1'b0, 8'h52}: e = entry(2'h1, 2'h2, 3'h2, 1'b0); // R11
      {1'b0, 8'h91}: e = entry(2'h2, 2'h2, 3'h1, 1'b0); // R11
      {1'b0, 8'h1c}: e = entry(2'h0, 2'h3, 3'h4, 1'b0); // R11
      {1'b0, 8'h5b}: e = entry(2'h1, 2'h3, 3'h3, 1'b0); // R11
      {1'b0, 8'h9a}: e = entry(2'h2, 2'h3, 3'h2, 1'b0); // R11
      {1'b1, 8'h00}: e = entry(2'h0, 2'h0, 3'h0, 1'b0); // R13
      {1'b1, 8'h01}: e = entry(2'h0, 2'h0, 3'h1, 1'b0); // R13
      {1'b1, 8'h40}: e = entry(2'h1, 2'h0, 3'h0, 1'b0); // R13
      {1'b1, 8'h41}: e = entry(2'h1, 2'h0, 3'h1, 1'b0); // R13
      {1'b1, 8'h42}: e = entry(2'h1, 2'h0, 3'h2, 1'b0); // R13
      {1'b1, 8'h80}: e = entry(2'h2, 2'h0, 3'h0, 1'b0); // R13
      {1'b1, 8'h81}: e = entry(2'h2, 2'h0, 3'h1, 1'b0); // R13
      {1'b1, 8'h09}: e = entry(2'h0, 2'h1, 3'h1, 1'b0); // R14
      {1'b1, 8'h48}: e = entry(2'h1, 2'h1, 3'h0, 1'b0); // R14
      {1'b1, 8'h49}: e = entry(2'h1, 2'h1, 3'h1, 1'b0); // R14
      {1'b1, 8'h88}: e = entry(2'h2, 2'h1, 3'h0, 1'b0); // R14
      {1'b1, 8'h89}: e = entry(2'h2, 2'h1, 3'h1, 1'b0); // R14
      {1'b1, 8'h8a}: e = entry(2'h2, 2'h1, 3'h2, 1'b0); // R14
      default:       e = '0;
    endcase
    return e;
  endfunction

  assign n8       = link_ctrl_r[`SLD_BIT_CONT_8];
  assign power_up = link_ctrl_r[`SLD_BIT_POWER_UP];
  assign dec      = decode(quick_r, n8); // R18
  // Base-two logs of N', S and the rate multiple; only meaningful for valid codes.
  assign lg_n     = n8 ? 4'h3 : 4'h4;
  assign lg_s     = 4'h3 + {1'b0, dec.lg_f} + {2'h0, dec.lg_l} - {2'h0, dec.lg_m} - lg_n;
  assign lg_r     = {2'h0, dec.lg_m} + lg_n - 4'h1 - {2'h0, dec.lg_l};

  // Register writes; the link itself is only gated by the power-up bit, so
  // reprogramming while powered up takes effect one cycle later.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dcm_r       <= `SLD_RST_DCM;
      lane_rate_r <= `SLD_RST_LANE_RATE;
      quick_r     <= `SLD_RST_QUICK;
      link_ctrl_r <= `SLD_RST_LINK_CTRL;
    end else if (i_reg_wr) begin
      unique case (i_reg_addr)
        `SLD_ADDR_DCM:       dcm_r       <= i_reg_wdata;
        `SLD_ADDR_LANE_RATE: lane_rate_r <= i_reg_wdata;
        `SLD_ADDR_QUICK:     quick_r     <= i_reg_wdata; // R2
        `SLD_ADDR_LINK_CTRL: link_ctrl_r <= i_reg_wdata;
        default:             ;
      endcase
    end
  end

  // Read data is registered and answered one cycle after the strobe.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_rdata  <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        unique case (i_reg_addr)
          `SLD_ADDR_DCM:       o_reg_rdata <= dcm_r;
          `SLD_ADDR_LANE_RATE: o_reg_rdata <= lane_rate_r;
          `SLD_ADDR_PLL_STAT:  o_reg_rdata <= {i_pll_locked, 7'h00}; // R16
          `SLD_ADDR_QUICK:     o_reg_rdata <= quick_r;
          `SLD_ADDR_LINK_CTRL: o_reg_rdata <= link_ctrl_r;
          `SLD_ADDR_LINK_STAT: o_reg_rdata <= {6'h00, o_m_mismatch, o_cfg_ok};
          default:             o_reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // Decoded parameters are registered; an unknown code drives zeros on all but the width and multiframe hints, and
  // keeps every lane off rather than guessing a neighbour entry.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_lane_en <= 4'h0;
      o_lanes   <= 3'h0;
      o_conv    <= 4'h0;
      o_octets  <= 5'h00;
      o_spf     <= 4'h0;
      o_hd      <= 1'b0;
      o_np      <= 5'h00;
      o_res_min <= 5'h00;
      o_res_max <= 5'h00;
      o_cs_max  <= 2'h0;
      o_k_min   <= 6'h00;
      o_rate_x4 <= 10'h000;
      o_cfg_ok  <= 1'b0;
    end else begin
      o_cfg_ok  <= dec.ok;
      if (dec.ok) begin
        // Only the first L lanes run, always as one link under one enable.
        o_lane_en <= power_up ? 4'((5'h01 << (3'h1 << dec.lg_l)) - 5'h01) : 4'h0; // R1
        o_lanes   <= 3'(3'h1 << dec.lg_l);
        o_conv    <= 4'(4'h1 << dec.lg_m);
        o_octets  <= 5'(5'h01 << dec.lg_f);
        o_spf     <= 4'(4'h1 << lg_s[1:0]);
        o_hd      <= dec.hd;
        // Lane rate in quarter units of the sample rate, 5*M*N'/L.
        o_rate_x4 <= 10'(`SLD_RATE_BASE << lg_r); // R4
      end else begin
        o_lane_en <= 4'h0;
        o_lanes   <= 3'h0;
        o_conv    <= 4'h0;
        o_octets  <= 5'h00;
        o_spf     <= 4'h0;
        o_hd      <= 1'b0;
        o_rate_x4 <= 10'h000;
      end
      o_np      <= n8 ? 5'h08 : 5'h10;
      o_res_min <= n8 ? `SLD_RES8_MIN : `SLD_RES16_MIN; // R12
      o_res_max <= n8 ? `SLD_RES8_MAX : `SLD_RES16_MAX; // R12
      o_cs_max  <= n8 ? `SLD_CS8_MAX : `SLD_CS16_MAX; // R12
      // Least legal multiframe length for this F, as a hint to the host.
      unique case (dec.lg_f)
        3'h0:    o_k_min <= `SLD_KMIN_F1;
        3'h1:    o_k_min <= `SLD_KMIN_F2;
        3'h2:    o_k_min <= `SLD_KMIN_F4;
        default: o_k_min <= `SLD_KMIN_F8;
      endcase
    end
  end

  // A mismatch only matters while the downconverters shape the stream.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_m_mismatch <= 1'b0;
    end else begin
      o_m_mismatch <= dec.ok && i_ddc_active &&
                      (4'(4'h1 << dec.lg_m) != i_virt_conv); // R3
    end
  end

  assign o_low_line_rate = lane_rate_r[`SLD_BIT_LOW_RATE];

  // Sample strobe: one pulse per decimation ratio clocks; zero counts as one
  // so that a ratio written as zero never stalls the stream.
  assign ratio = (dcm_r == 8'h00) ? 8'h01 : dcm_r;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div_cnt_r   <= 8'h00;
      o_sample_en <= 1'b0;
    end else if (div_cnt_r >= ratio - 8'h01) begin
      div_cnt_r   <= 8'h00;
      o_sample_en <= 1'b1; // R5
    end else begin
      div_cnt_r   <= div_cnt_r + 8'h01;
      o_sample_en <= 1'b0;
    end
  end

  // Helper for the sample-spacing check: clocks since the previous strobe.
  logic [8:0] gap_r;
  logic       seen_r;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      gap_r  <= 9'h000;
      seen_r <= 1'b0;
    end else if (o_sample_en) begin
      gap_r  <= 9'h001;
      seen_r <= !(i_reg_wr && i_reg_addr == `SLD_ADDR_DCM);
    end else begin
      gap_r  <= gap_r + 9'h001;
      seen_r <= seen_r && !(i_reg_wr && i_reg_addr == `SLD_ADDR_DCM);
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  lanes_one_link_a: assert property ( // R1
    o_lane_en == (o_cfg_ok && $past(power_up) ? 4'((5'h01 << o_lanes) - 5'h01) : 4'h0))
    else $error("lane enables do not match one link of L lanes");

  setup_write_a: assert property ( // R2
    i_reg_wr && i_reg_addr == `SLD_ADDR_QUICK && i_reg_wdata == 8'h91 && !n8 ##1 !i_reg_wr
    |=> o_lanes == 3'h4 && o_conv == 4'h4 && o_octets == 5'h02)
    else $error("quick setup code 0x91 did not select L, M and F together");

  quick_store_a: assert property ( // R2
    i_reg_wr && i_reg_addr == `SLD_ADDR_QUICK |=> quick_r == $past(i_reg_wdata))
    else $error("quick setup write not stored");

  conv_match_a: assert property ( // R3
    $past(dec.ok) && $past(i_ddc_active) && o_conv != $past(i_virt_conv)
    && !$past(i_reg_wr) |-> o_m_mismatch)
    else $error("converter mismatch not flagged");

  rate_calc_a: assert property ( // R4
    o_cfg_ok |-> int'(o_rate_x4) * int'(o_lanes) == 5 * int'(o_conv) * int'(o_np))
    else $error("lane rate multiplier wrong");

  sample_gap_a: assert property ( // R5
    o_sample_en && seen_r |-> gap_r == {1'b0, ratio})
    else $error("sample strobe spacing differs from decimation ratio");

  hd_code16_a: assert property ( // R10
    quick_r == 8'h40 && !n8 && $stable(quick_r) && $stable(n8) |=> o_hd && o_lanes == 3'h2)
    else $error("16-bit code 0x40 decoded wrongly");

  code16_eight_a: assert property ( // R11
    quick_r == 8'h9a && !n8 |=> o_lanes == 3'h4 && o_conv == 4'h8 && o_octets == 5'h04)
    else $error("16-bit code 0x9a decoded wrongly");

  res_range_a: assert property ( // R12
    n8 |=> o_res_min == 5'h07 && o_res_max == 5'h08 && o_cs_max == 2'h1)
    else $error("8-bit resolution range wrong");

  hd_clear8_a: assert property ( // R13
    n8 |=> !o_hd)
    else $error("high density set with 8-bit containers");

  code8_two_a: assert property ( // R14
    quick_r == 8'h8a && n8 |=> o_lanes == 3'h4 && o_conv == 4'h2 && o_octets == 5'h04)
    else $error("8-bit code 0x8a decoded wrongly");

  pll_status_a: assert property ( // R16
    i_reg_rd && i_reg_addr == `SLD_ADDR_PLL_STAT |=> o_reg_rvalid
    && o_reg_rdata == {$past(i_pll_locked), 7'h00})
    else $error("PLL status read wrong");

  width_decode_a: assert property ( // R18
    quick_r == 8'h00 |=> o_cfg_ok == $past(n8))
    else $error("code 0x00 validity ignores container width");

  // Main scenarios.
  link_up_c:  cover property (o_cfg_ok && o_lane_en == 4'hf);
  mismatch_c: cover property (o_m_mismatch);
  low_rate_c: cover property (o_low_line_rate && o_cfg_ok);
  decim_c:    cover property (o_sample_en && dcm_r > 8'h01);

endmodule

// >>> rtl/sld_cfg.svh
// Offsets, field positions, reset values and constants of the link setup decoder.
`ifndef SLD_CFG_SVH
`define SLD_CFG_SVH
`define SLD_ADDR_DCM        12'h201
`define SLD_ADDR_LANE_RATE  12'h56e
`define SLD_ADDR_PLL_STAT   12'h56f
`define SLD_ADDR_QUICK      12'h570
`define SLD_ADDR_LINK_CTRL  12'h571
`define SLD_ADDR_LINK_STAT  12'h572
`define SLD_BIT_LOW_RATE    4
`define SLD_BIT_PLL_LOCK    7
`define SLD_BIT_POWER_UP    0
`define SLD_BIT_CONT_8      1
`define SLD_RST_DCM         8'h01
`define SLD_RST_LANE_RATE   8'h00
`define SLD_RST_QUICK       8'h81
`define SLD_RST_LINK_CTRL   8'h00
`define SLD_RATE_BASE       10'h00a
`define SLD_KMIN_F1         6'h14
`define SLD_KMIN_F2         6'h0c
`define SLD_KMIN_F4         6'h08
`define SLD_KMIN_F8         6'h04
`define SLD_RES16_MIN       5'h08
`define SLD_RES16_MAX       5'h10
`define SLD_RES8_MIN        5'h07
`define SLD_RES8_MAX        5'h08
`define SLD_CS16_MAX        2'h3
`define SLD_CS8_MAX         2'h1
`endif

// >>> rtl/sld_pkg.sv
// Types shared by the link setup decoder.
package sld_pkg;
  // One decoded quick-setup entry, counts kept as base-two logarithms.
  typedef struct packed {
    logic       ok;
    logic [1:0] lg_l;
    logic [1:0] lg_m;
    logic [2:0] lg_f;
    logic       hd;
  } sld_qcfg_t;
endpackage

// >>> testbench/sld_rx_model.sv
// Far-end receiver and serializer lock model for the link setup decoder.
`timescale 1ns/100ps
module sld_rx_model #(
  parameter int FOUT_MSPS   = 1000,
  parameter int LOCK_CYCLES = 4
) (
  // Clock and reset.
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  // Link setup seen from the device.
  input  wire logic [3:0] i_lane_en,
  input  wire logic [9:0] i_rate_x4,
  input  wire logic       i_low_line_rate,
  // Lock report back to the device.
  output logic            o_pll_locked
);
  int  rate_mbps;
  int  lock_cnt_r;
  logic rate_good;

  // Lane rate from the decoded figure; lock only inside the supported band with a matching mode.
  always_comb begin
    rate_mbps = int'(i_rate_x4) * FOUT_MSPS / 4;
    rate_good = (|i_lane_en) && rate_mbps >= 3125 && rate_mbps <= 12500
                && (i_low_line_rate == (rate_mbps < 6250));
  end

  // A lock takes a few cycles, so a hasty status read sees it still open.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lock_cnt_r <= 0;
    end else if (!rate_good) begin
      lock_cnt_r <= 0;
    end else if (lock_cnt_r < LOCK_CYCLES) begin
      lock_cnt_r <= lock_cnt_r + 1;
    end
  end
  assign o_pll_locked = (lock_cnt_r == LOCK_CYCLES);
endmodule

// >>> testbench/tb_sld_link_setup.sv
// Self-checking bench for the quick-setup decoder and its registers.
`timescale 1ns/100ps
module tb_sld_link_setup;
  logic        i_clk, i_reset_n, i_reg_wr, i_reg_rd, i_ddc_active, i_pll_locked;
  logic [11:0] i_reg_addr;
  logic [7:0]  i_reg_wdata, o_reg_rdata;
  logic [3:0]  i_virt_conv, o_lane_en, o_conv, o_spf;
  logic [2:0]  o_lanes;
  logic [4:0]  o_octets, o_np, o_res_min, o_res_max;
  logic [1:0]  o_cs_max;
  logic [5:0]  o_k_min;
  logic [9:0]  o_rate_x4;
  logic        o_reg_rvalid, o_hd, o_cfg_ok, o_m_mismatch, o_low_line_rate, o_sample_en;
  int          bad_count, samples_checked, seed, r, n;
  logic [31:0] exp_q[$];
  // Entries read as code, L, M, F, high density.
  logic [27:0] t16[15] = '{28'h01_1_1_02_0, 28'h40_2_1_01_1, 28'h41_2_1_02_0, 28'h80_4_1_01_1,
    28'h81_4_1_02_0, 28'h0a_1_2_04_0, 28'h49_2_2_02_0, 28'h88_4_2_01_1, 28'h89_4_2_02_0,
    28'h13_1_4_08_0, 28'h52_2_4_04_0, 28'h91_4_4_02_0, 28'h1c_1_8_10_0, 28'h5b_2_8_08_0,
    28'h9a_4_8_04_0};
  logic [27:0] t8[13] = '{28'h00_1_1_01_0, 28'h01_1_1_02_0, 28'h40_2_1_01_0, 28'h41_2_1_02_0,
    28'h42_2_1_04_0, 28'h80_4_1_01_0, 28'h81_4_1_02_0, 28'h09_1_2_02_0, 28'h48_2_2_01_0,
    28'h49_2_2_02_0, 28'h88_4_2_01_0, 28'h89_4_2_02_0, 28'h8a_4_2_04_0};

  sld_link_setup dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_pll_locked(i_pll_locked),
    .i_ddc_active(i_ddc_active), .i_virt_conv(i_virt_conv), .o_lane_en(o_lane_en),
    .o_lanes(o_lanes), .o_conv(o_conv), .o_octets(o_octets), .o_spf(o_spf), .o_hd(o_hd),
    .o_np(o_np), .o_res_min(o_res_min), .o_res_max(o_res_max), .o_cs_max(o_cs_max),
    .o_k_min(o_k_min), .o_rate_x4(o_rate_x4), .o_cfg_ok(o_cfg_ok),
    .o_m_mismatch(o_m_mismatch), .o_low_line_rate(o_low_line_rate),
    .o_sample_en(o_sample_en));

  sld_rx_model u_rx (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_lane_en(o_lane_en),
    .i_rate_x4(o_rate_x4), .i_low_line_rate(o_low_line_rate), .o_pll_locked(i_pll_locked));

  // Clock at 100 MHz.
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      bad_count++;
    end
  endtask

  task automatic print_verdict;
    $display("mismatches=%0d comparisons=%0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Each strobe is held for exactly one edge, so the next request waits one idle cycle.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_reg_wr <= 1'b1; i_reg_addr <= a; i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    @(posedge i_clk);
    i_reg_rd <= 1'b1; i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
  endtask

  function automatic logic [31:0] kmin(input int f);
    return (f == 1) ? 20 : (f == 2) ? 12 : (f == 4) ? 8 : 4;
  endfunction

  // Write one code, then compare every decoded field one cycle after the write lands.
  task automatic dec(input logic [27:0] e, input int np);
    int l, m, f;
    l = e[19:16]; m = e[15:12]; f = e[11:4];
    wr(12'h570, e[27:20]);
    @(posedge i_clk); #1;
    chk({o_lanes, o_conv, o_octets, o_hd}, {3'(l), 4'(m), 5'(f), e[0]});
    chk(o_rate_x4, 5 * m * np / l);
    chk(o_spf, 8 * f * l / (m * np));
    chk({o_np, o_res_min, o_res_max, o_cs_max},
        (np == 16) ? {5'h10, 5'h08, 5'h10, 2'h3} : {5'h08, 5'h07, 5'h08, 2'h1});
    chk(o_k_min, kmin(f));
    chk({o_cfg_ok, o_lane_en}, {1'b1, 4'((1 << l) - 1)});
    rd(12'h570, e[27:20]);
  endtask

  // Read results are paired with the oldest expectation when the valid pulse shows.
  always @(posedge i_clk) begin
    if (o_reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) chk(32'h1, 32'h0);
      else chk({24'h0, o_reg_rdata}, exp_q.pop_front());
    end
  end

  // Watchdog: the whole sequence needs only a few hundred cycles.
  initial begin
    #200us;
    bad_count++;
    print_verdict;
  end

  // Main sequence.
  initial begin
    {i_reg_wr, i_reg_rd, i_ddc_active} = 3'h0;
    i_reg_addr = 12'h000; i_reg_wdata = 8'h00; i_virt_conv = 4'h1; i_reset_n = 1'b0;
    seed = 81252; bad_count = 0; samples_checked = 0;
    repeat (3) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rd(12'h201, 8'h01);
    rd(12'h56e, 8'h00);
    rd(12'h570, 8'h81);
    rd(12'h571, 8'h00);
    rd(12'h123, 8'h00);
    wr(12'h56f, 8'hff);
    rd(12'h56f, 8'h00);
    wr(12'h571, 8'h01);
    foreach (t16[i]) dec(t16[i], 16);
    wr(12'h571, 8'h03);
    foreach (t8[i]) dec(t8[i], 8);
    // Code 0x8a is only defined for 8-bit containers, so widening must reject it.
    wr(12'h571, 8'h01);
    @(posedge i_clk); #1;
    chk({o_cfg_ok, o_lanes, o_lane_en}, 32'h0);
    rd(12'h572, 8'h00);
    i_ddc_active <= 1'b1; i_virt_conv <= 4'h8;
    wr(12'h570, 8'h9a);
    rd(12'h572, 8'h01);
    wr(12'h570, 8'h91);
    rd(12'h572, 8'h03);
    chk(o_m_mismatch, 1);
    i_ddc_active <= 1'b0;
    wr(12'h571, 8'h00); wr(12'h570, 8'h81); wr(12'h56e, 8'h10); wr(12'h571, 8'h01);
    repeat (10) @(posedge i_clk);
    rd(12'h56f, 8'h80);
    chk(o_low_line_rate, 1);
    wr(12'h570, 8'h88);
    repeat (10) @(posedge i_clk);
    rd(12'h56f, 8'h00);
    wr(12'h56e, 8'h00);
    repeat (10) @(posedge i_clk);
    rd(12'h56f, 8'h80);
    wr(12'h570, 8'h1c);
    repeat (10) @(posedge i_clk);
    rd(12'h56f, 8'h00);
    repeat (4) begin
      r = 1 + ($unsigned($random(seed)) % 5);
      wr(12'h201, 8'(r));
      repeat (10) @(posedge i_clk);
      n = 0;
      do @(posedge i_clk); while (o_sample_en !== 1'b1 && ++n < 20);
      n = 0;
      do begin @(posedge i_clk); n++; end while (o_sample_en !== 1'b1 && n < 20);
      chk(n, r);
    end
    repeat (5) @(posedge i_clk);
    chk(exp_q.size(), 0);
    print_verdict;
  end
endmodule
